// *** rtl/isp_ctl_ifs.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Controller to state walker
// ----------------------------------------
interface tap_link_if;
	import isp_ctl_pkg::*;
	logic step;
	logic tms;
	logic enable;
	tap_e state;
	modport ctl (output step, output tms, output enable, input state);
	modport fsm (input step, input tms, input enable, output state);
endinterface

// ----------------------------------------
// Controller to pattern store
// ----------------------------------------
interface store_link_if;
	import isp_ctl_pkg::*;
	logic erase;
	logic write;
	logic [ISP_LEN-1:0] wr_word;
	logic [ISP_AW-1:0] rd_addr;
	logic [ISP_DW-1:0] rd_data;
	logic programmed;
	logic rp;
	logic wp;
	modport ctl (output erase, output write, output wr_word, output rd_addr,
		input rd_data, input programmed, input rp, input wp);
	modport mem (input erase, input write, input wr_word, input rd_addr,
		output rd_data, output programmed, output rp, output wp);
endinterface

// *** rtl/isp_ctl_pkg.sv ***
package isp_ctl_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int INIT_TIME_US = 100;
	// Longest init time, rounded down to whole cycles
	localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// Register widths and ISP word layout
	// ----------------------------------------
	localparam int IR_W = 8;
	localparam int DR_W = 32;
	localparam int ISP_AW = 4;
	localparam int ISP_DW = 8;
	localparam int ISP_DEPTH = 16;
	localparam int ISP_DATA_LSB = 0;
	localparam int ISP_ADDR_LSB = ISP_DW;
	localparam int ISP_WP_BIT = ISP_DW + ISP_AW;
	localparam int ISP_RP_BIT = ISP_DW + ISP_AW + 1;
	localparam int ISP_LEN = ISP_DW + ISP_AW + 2;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
	localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
	localparam logic [IR_W-1:0] OP_INTEST = 8'h02;
	localparam logic [IR_W-1:0] OP_IDCODE = 8'h03;
	localparam logic [IR_W-1:0] OP_USERCODE = 8'h04;
	localparam logic [IR_W-1:0] OP_HIGHZ = 8'h05;
	localparam logic [IR_W-1:0] OP_ENTER = 8'h10;
	localparam logic [IR_W-1:0] OP_ERASE = 8'h11;
	localparam logic [IR_W-1:0] OP_PROGRAM = 8'h12;
	localparam logic [IR_W-1:0] OP_VERIFY = 8'h13;
	localparam logic [IR_W-1:0] OP_EXIT = 8'h14;
	localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;

	// ----------------------------------------
	// State encodings
	// ----------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
		TAP_CAPTURE_DR = 4'b0011, TAP_SHIFT_DR = 4'b0100, TAP_EXIT1_DR = 4'b0101,
		TAP_PAUSE_DR = 4'b0110, TAP_EXIT2_DR = 4'b0111, TAP_UPDATE_DR = 4'b1000,
		TAP_SEL_IR = 4'b1001, TAP_CAPTURE_IR = 4'b1010, TAP_SHIFT_IR = 4'b1011,
		TAP_EXIT1_IR = 4'b1100, TAP_PAUSE_IR = 4'b1101, TAP_EXIT2_IR = 4'b1110,
		TAP_UPDATE_IR = 4'b1111
	} tap_e;

	typedef enum logic [1:0] {
		PWR_QUIET = 2'b00,
		PWR_INIT = 2'b01,
		PWR_RUN = 2'b10
	} pwr_e;

endpackage

// *** rtl/isp_security_powerup_control.sv ***
`timescale 1ns/100ps

// Contract
// - During programming, all user pins float with pull-ups on.
// - Test port runs standard boundary-scan instructions.
// - Five programming instructions decoded: enter, erase, program, verify, exit.
// - Read protection blocks any readback of the stored pattern.
// - Only a full erase clears read protection.
// - Write protection inhibits erase and program.
// - Write protection can be released; host releases it before reprogramming.
// - Read and write protection bits combine independently, four settings.
// - Stay quiescent until supply-good indication arrives.
// - Quiescent: pins, logic and test controller off, pull-ups on.
// - After supply good, initialise user registers within 100 us, then run.
// - Erased device keeps pins and logic off, pull-ups on; EXTEST still drives the pins while running outside programming.
// - Erased device keeps test controller enabled.
// - Programmed device runs pins and logic, pull-ups off.
// - Programmed device keeps test controller enabled.
// - User registers load preload value at init, zero by default.
module isp_security_powerup_control import isp_ctl_pkg::*; #(
	parameter int IO_W = 8,
	parameter int INIT_CNT = INIT_CYCLES,
	parameter logic [IO_W-1:0] PRELOAD = '0,
	parameter logic [DR_W-1:0] ID_CODE = 32'h1234_5671, // Arbitrary value
	parameter logic [DR_W-1:0] USER_CODE = 32'h0000_0000 // Arbitrary value
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic vcc_good_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_b_out,
	input wire logic [IO_W-1:0] user_pin_in,
	output logic [IO_W-1:0] user_pin_out,
	output logic user_pin_oe_b_out,
	output logic pull_up_en_out,
	input wire logic [IO_W-1:0] user_core_in,
	output logic [IO_W-1:0] user_in_out,
	output logic user_logic_en_out,
	output logic global_set_reset_out,
	output logic in_system_programming_out
);

	localparam int CNT_W = $clog2(INIT_CNT + 1);
	typedef struct packed {
		logic tck1;
		logic tck2;
		logic tck3;
		logic tms1;
		logic tms2;
		logic tdi1;
		logic tdi2;
		logic vg1;
		logic vg2;
		logic [IO_W-1:0] pin1;
		logic [IO_W-1:0] pin2;
		pwr_e pwr;
		logic [CNT_W-1:0] cnt;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sr;
		logic [DR_W-1:0] dr_sr;
		logic [IO_W-1:0] bnd;
		logic [ISP_AW-1:0] rd_addr;
		logic isp;
		logic erase;
		logic write;
		logic [ISP_LEN-1:0] wr_word;
		logic tdo;
		logic tdo_oe_b;
		logic [IO_W-1:0] user_reg;
		logic [IO_W-1:0] user_pin;
		logic [IO_W-1:0] user_in;
		logic oe_b;
		logic pull;
		logic logic_en;
		logic global_set_reset;
	} ctl_s;

	ctl_s cur_reg;
	ctl_s cur_next;
	logic tck_rise;
	logic tck_fall;
	logic run;
	logic user_mode;
	logic [ISP_LEN-1:0] isp_word;
	tap_link_if tap_l ();
	store_link_if st_l ();

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_bnd(input logic [IR_W-1:0] op);
		is_bnd = (op == OP_EXTEST) || (op == OP_SAMPLE) || (op == OP_INTEST);
	endfunction

	function automatic int dr_len(input logic [IR_W-1:0] op);
		dr_len = (op == OP_IDCODE || op == OP_USERCODE) ? DR_W : is_bnd(op) ? IO_W :
			(op == OP_PROGRAM || op == OP_VERIFY) ? ISP_LEN : 1;
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	tap_walker u_walker (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.tap(tap_l.fsm)
	);

	pattern_store u_store (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.st(st_l.mem)
	);

	// Edge finding on the synchronised test clock
	assign tck_rise = cur_reg.tck2 & ~cur_reg.tck3;
	assign tck_fall = ~cur_reg.tck2 & cur_reg.tck3;
	assign run = (cur_reg.pwr == PWR_RUN);
	assign user_mode = run && st_l.programmed && !cur_reg.isp;
	assign isp_word = {st_l.rp, st_l.wp, cur_reg.rd_addr, st_l.rd_data};

	// Links to submodules
	assign tap_l.step = tck_rise;
	assign tap_l.tms = cur_reg.tms2;
	assign tap_l.enable = run;
	assign st_l.erase = cur_reg.erase;
	assign st_l.write = cur_reg.write;
	assign st_l.wr_word = cur_reg.wr_word;
	assign st_l.rd_addr = cur_reg.rd_addr;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		cur_next = cur_reg;
		cur_next.tck1 = tck_in;
		cur_next.tck2 = cur_reg.tck1;
		cur_next.tck3 = cur_reg.tck2;
		cur_next.tms1 = tms_in;
		cur_next.tms2 = cur_reg.tms1;
		cur_next.tdi1 = tdi_in;
		cur_next.tdi2 = cur_reg.tdi1;
		cur_next.vg1 = vcc_good_in;
		cur_next.vg2 = cur_reg.vg1;
		cur_next.pin1 = user_pin_in;
		cur_next.pin2 = cur_reg.pin1;
		cur_next.erase = 1'b0;
		cur_next.write = 1'b0;
		// Power-up sequencing
		case (cur_reg.pwr)
			PWR_QUIET: begin
				if (cur_reg.vg2) begin
					cur_next.pwr = PWR_INIT;
					cur_next.cnt = '0;
				end
			end
			PWR_INIT: begin
				cur_next.cnt = cur_reg.cnt + 1'b1;
				if (cur_reg.cnt == CNT_W'(INIT_CNT - 1)) begin
					cur_next.pwr = PWR_RUN;
				end
			end
			PWR_RUN: cur_next.cnt = cur_reg.cnt;
			default: cur_next.pwr = PWR_QUIET;
		endcase
		// Test port actions
		if (run) begin
			if (tck_rise) begin
				case (tap_l.state)
					TAP_RESET: cur_next.ir = OP_IDCODE;
					TAP_CAPTURE_IR: cur_next.ir_sr = IR_CAPTURE;
					TAP_SHIFT_IR: cur_next.ir_sr = {cur_reg.tdi2, cur_reg.ir_sr[IR_W-1:1]};
					TAP_CAPTURE_DR: begin
						if (cur_reg.ir == OP_IDCODE) begin
							cur_next.dr_sr = ID_CODE;
						end else if (cur_reg.ir == OP_USERCODE) begin
							cur_next.dr_sr = USER_CODE;
						end else if (is_bnd(cur_reg.ir)) begin
							cur_next.dr_sr = DR_W'(cur_reg.pin2);
						end else if (cur_reg.ir == OP_VERIFY || cur_reg.ir == OP_PROGRAM) begin
							cur_next.dr_sr = DR_W'(isp_word);
						end else begin
							cur_next.dr_sr = '0;
						end
					end
					TAP_SHIFT_DR: begin
						cur_next.dr_sr = cur_reg.dr_sr >> 1;
						cur_next.dr_sr[dr_len(cur_reg.ir) - 1] = cur_reg.tdi2;
					end
					default: cur_next.ir_sr = cur_reg.ir_sr;
				endcase
			end
			if (tck_fall) begin
				cur_next.tdo_oe_b = 1'b1;
				case (tap_l.state)
					TAP_SHIFT_IR: begin
						cur_next.tdo = cur_reg.ir_sr[0];
						cur_next.tdo_oe_b = 1'b0;
					end
					TAP_SHIFT_DR: begin
						cur_next.tdo = cur_reg.dr_sr[0];
						cur_next.tdo_oe_b = 1'b0;
					end
					TAP_UPDATE_IR: begin
						cur_next.ir = cur_reg.ir_sr;
						if (cur_reg.ir_sr == OP_ENTER) begin
							cur_next.isp = 1'b1;
						end else if (cur_reg.ir_sr == OP_EXIT && cur_reg.isp) begin
							cur_next.isp = 1'b0;
							cur_next.pwr = PWR_INIT;
							cur_next.cnt = '0;
						end else if (cur_reg.ir_sr == OP_ERASE && cur_reg.isp) begin
							cur_next.erase = 1'b1;
						end
					end
					TAP_UPDATE_DR: begin
						if (is_bnd(cur_reg.ir)) begin
							cur_next.bnd = cur_reg.dr_sr[IO_W-1:0];
						end else if (cur_reg.ir == OP_PROGRAM && cur_reg.isp) begin
							cur_next.write = 1'b1;
							cur_next.wr_word = cur_reg.dr_sr[ISP_LEN-1:0];
						end else if (cur_reg.ir == OP_VERIFY && cur_reg.isp) begin
							cur_next.rd_addr = cur_reg.dr_sr[ISP_ADDR_LSB +: ISP_AW];
						end
					end
					default: cur_next.tdo = cur_reg.tdo;
				endcase
			end
		end else begin
			cur_next.tdo_oe_b = 1'b1;
			cur_next.ir = OP_IDCODE;
		end

		// Supply loss forces quiescence
		if (!cur_reg.vg2) begin
			cur_next.pwr = PWR_QUIET;
			cur_next.isp = 1'b0;
			cur_next.cnt = '0;
		end

		// User pins, pull-ups and logic per device state
		cur_next.pull = !user_mode;
		cur_next.logic_en = user_mode;
		cur_next.oe_b = 1'b1;
		cur_next.user_pin = cur_reg.user_reg;
		if (run && !cur_reg.isp && cur_reg.ir == OP_EXTEST) begin
			cur_next.oe_b = 1'b0;
			cur_next.user_pin = cur_reg.bnd;
		end else if (user_mode && cur_reg.ir != OP_HIGHZ && cur_reg.ir != OP_INTEST) begin
			cur_next.oe_b = 1'b0;
		end
		cur_next.user_in = '0;
		if (user_mode) begin
			cur_next.user_in = (cur_reg.ir == OP_INTEST) ? cur_reg.bnd : cur_reg.pin2;
		end

		// User registers: preload until running, follow logic in user mode
		cur_next.global_set_reset = (cur_reg.pwr == PWR_INIT);
		if (!run) begin
			cur_next.user_reg = PRELOAD;
		end else if (user_mode) begin
			cur_next.user_reg = user_core_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur_reg <= '0;
			cur_reg.ir <= OP_IDCODE;
			cur_reg.tdo_oe_b <= 1'b1;
			cur_reg.oe_b <= 1'b1;
			cur_reg.pull <= 1'b1;
			cur_reg.user_reg <= PRELOAD;
			cur_reg.user_pin <= PRELOAD;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Outputs straight from flops
	assign tdo_out = cur_reg.tdo;
	assign tdo_oe_b_out = cur_reg.tdo_oe_b;
	assign user_pin_out = cur_reg.user_pin;
	assign user_pin_oe_b_out = cur_reg.oe_b;
	assign pull_up_en_out = cur_reg.pull;
	assign user_in_out = cur_reg.user_in;
	assign user_logic_en_out = cur_reg.logic_en;
	assign global_set_reset_out = cur_reg.global_set_reset;
	assign in_system_programming_out = cur_reg.isp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	chk_isp_pins_float: assert property (
		cur_reg.isp |=> user_pin_oe_b_out && pull_up_en_out && !user_logic_en_out)
		else $error("pins driven during programming");
	chk_enter_decode: assert property (
		run && cur_reg.vg2 && tck_fall && tap_l.state == TAP_UPDATE_IR &&
		cur_reg.ir_sr == OP_ENTER |=> in_system_programming_out)
		else $error("enter instruction not taken");
	chk_erase_decode: assert property (
		run && cur_reg.vg2 && tck_fall && tap_l.state == TAP_UPDATE_IR &&
		cur_reg.ir_sr == OP_ERASE && cur_reg.isp |=> st_l.erase ##1 !st_l.erase)
		else $error("erase instruction not one pulse");
	chk_supply_wait: assert property (!cur_reg.vg2 |=> cur_reg.pwr == PWR_QUIET)
		else $error("left quiescence without supply");
	chk_quiet_off: assert property (
		cur_reg.pwr == PWR_QUIET |=> pull_up_en_out && user_pin_oe_b_out &&
		!user_logic_en_out && tdo_oe_b_out)
		else $error("device active while quiescent");
	chk_init_end: assert property (
		cur_reg.pwr == PWR_INIT && cur_reg.vg2 && cur_reg.cnt == CNT_W'(INIT_CNT - 1) |=>
		cur_reg.pwr == PWR_RUN ##1 !global_set_reset_out)
		else $error("init did not end on time");
	chk_erased_off: assert property (
		run && !st_l.programmed |=> pull_up_en_out && !user_logic_en_out)
		else $error("erased device not held off");
	chk_tap_alive: assert property (
		run && cur_reg.vg2 && tck_rise && !cur_reg.tms2 && tap_l.state == TAP_RESET |=>
		tap_l.state == TAP_IDLE)
		else $error("test controller disabled while running");
	chk_user_run: assert property (
		user_mode |=> !pull_up_en_out && user_logic_en_out)
		else $error("programmed device not operating");
	chk_preload: assert property (cur_reg.pwr == PWR_INIT |=> cur_reg.user_reg == PRELOAD)
		else $error("user register not preloaded");
	cov_reach_run: cover property ($rose(run));
	cov_isp_session: cover property ($rose(cur_reg.isp));
	cov_program: cover property (st_l.write && !st_l.wp);
	cov_user_mode: cover property ($rose(user_mode));

endmodule

// *** rtl/pattern_store.sv ***
`timescale 1ns/100ps

module pattern_store import isp_ctl_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	store_link_if.mem st
);

	typedef struct packed {
		logic [ISP_DEPTH-1:0][ISP_DW-1:0] mem;
		logic programmed;
		logic rp;
		logic wp;
	} store_s;

	store_s cur_reg;
	store_s cur_next;

	// ----------------------------------------
	// Erase and program, gated by protection
	// ----------------------------------------
	always_comb begin
		cur_next = cur_reg;
		if (st.erase && !cur_reg.wp) begin
			cur_next.mem = '0;
			cur_next.programmed = 1'b0;
			cur_next.rp = 1'b0;
		end else if (st.write) begin
			if (!cur_reg.wp) begin
				cur_next.mem[st.wr_word[ISP_ADDR_LSB +: ISP_AW]] =
					st.wr_word[ISP_DATA_LSB +: ISP_DW];
				cur_next.programmed = 1'b1;
				cur_next.rp = cur_reg.rp | st.wr_word[ISP_RP_BIT];
				cur_next.wp = st.wr_word[ISP_WP_BIT];
			end else if (!st.wr_word[ISP_WP_BIT]) begin
				cur_next.wp = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Readback masked while read protected
	assign st.rd_data = cur_reg.rp ? '0 : cur_reg.mem[st.rd_addr];
	assign st.programmed = cur_reg.programmed;
	assign st.rp = cur_reg.rp;
	assign st.wp = cur_reg.wp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	chk_read_masked: assert property (cur_reg.rp |-> st.rd_data == '0)
		else $error("pattern readable while protected");
	chk_rp_erase_only: assert property (
		$fell(cur_reg.rp) |-> $past(st.erase) && !$past(cur_reg.wp))
		else $error("read protect cleared without erase");
	chk_wp_blocks: assert property (
		cur_reg.wp && (st.erase || st.write) |=> $stable(cur_reg.mem))
		else $error("pattern changed while write protected");
	chk_wp_release: assert property (
		cur_reg.wp && st.write && !st.erase && !st.wr_word[ISP_WP_BIT] |=> !cur_reg.wp)
		else $error("write protect not released");
	chk_bits_independent: assert property (
		!cur_reg.wp && st.write && !st.erase |=>
		cur_reg.wp == $past(st.wr_word[ISP_WP_BIT]) && cur_reg.rp >= $past(cur_reg.rp))
		else $error("protect bits not set independently");

	cov_both_set: cover property (cur_reg.rp && cur_reg.wp);

endmodule

// *** rtl/tap_walker.sv ***
`timescale 1ns/100ps

module tap_walker import isp_ctl_pkg::*; (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	tap_link_if.fsm tap
);

	typedef struct packed {
		tap_e st;
	} walk_s;

	walk_s cur_reg;
	walk_s cur_next;

	// Standard test-state transition on one test clock rise
	function automatic tap_e next_state(input tap_e s, input logic m);
		case (s)
			TAP_RESET: next_state = m ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: next_state = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: next_state = m ? TAP_SEL_IR : TAP_CAPTURE_DR;
			TAP_CAPTURE_DR: next_state = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: next_state = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: next_state = m ? TAP_UPDATE_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: next_state = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: next_state = m ? TAP_UPDATE_DR : TAP_SHIFT_DR;
			TAP_UPDATE_DR: next_state = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: next_state = m ? TAP_RESET : TAP_CAPTURE_IR;
			TAP_CAPTURE_IR: next_state = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: next_state = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: next_state = m ? TAP_UPDATE_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: next_state = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: next_state = m ? TAP_UPDATE_IR : TAP_SHIFT_IR;
			TAP_UPDATE_IR: next_state = m ? TAP_SEL_DR : TAP_IDLE;
			default: next_state = TAP_RESET;
		endcase
	endfunction

	// ----------------------------------------
	// State walk, held in reset while disabled
	// ----------------------------------------
	always_comb begin
		cur_next = cur_reg;
		if (!tap.enable) begin
			cur_next.st = TAP_RESET;
		end else if (tap.step) begin
			cur_next.st = next_state(cur_reg.st, tap.tms);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur_reg.st <= TAP_RESET;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign tap.state = cur_reg.st;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	chk_walk_disabled: assert property (!tap.enable |=> tap.state == TAP_RESET)
		else $error("walker left reset while disabled");
	chk_walk_idle_hold: assert property (
		tap.enable && tap.step && !tap.tms && tap.state == TAP_IDLE |=>
		tap.state == TAP_IDLE)
		else $error("idle not held with mode low");

endmodule

// *** testbench/isp_security_powerup_control_bench.sv ***
`timescale 1ns/100ps

module isp_security_powerup_control_bench;
	import isp_ctl_pkg::*;
	localparam int IO_W = 8;
	localparam int INIT_N = 20;
	localparam logic [IO_W-1:0] PRE = 8'h5A;
	localparam logic [31:0] ID = 32'h0BAD_0001; // Arbitrary value
	localparam logic [31:0] UC = 32'h0000_C0DE; // Arbitrary value
	logic core_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic vcc_good_in = 1'b0;
	logic [IO_W-1:0] pin_in = '0;
	logic [IO_W-1:0] core_in = '0;
	wire logic tck, tms, tdi, tdo, tdo_oe_b, oe_b, pu, len, global_set_reset, isp;
	wire logic [IO_W-1:0] pin_out, uin;
	wire logic [2:0] mode = {pu, oe_b, len};
	int errors = 0;
	int tests_run = 0;
	logic [63:0] notes[$];

	isp_security_powerup_control #(.IO_W(IO_W), .INIT_CNT(INIT_N), .PRELOAD(PRE),
		.ID_CODE(ID), .USER_CODE(UC)) uut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.vcc_good_in(vcc_good_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo),
		.tdo_oe_b_out(tdo_oe_b), .user_pin_in(pin_in), .user_pin_out(pin_out),
		.user_pin_oe_b_out(oe_b), .pull_up_en_out(pu), .user_core_in(core_in),
		.user_in_out(uin), .user_logic_en_out(len), .global_set_reset_out(global_set_reset),
		.in_system_programming_out(isp));
	jtag_host host (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
		.tdo_oe_b_in(tdo_oe_b));

	always #2.5 core_clk_in = ~core_clk_in;

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Each finished scan is matched with the oldest note
	always @(host.got) begin
		logic [63:0] n;
		if (notes.size() == 0) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, host.last, 32'h0000_0000);
		end else begin
			n = notes.pop_front();
			if (n[63:32] != 0) chk(host.last & n[63:32], n[31:0]);
		end
	end

	// ----------------------------------------
	// Port traffic
	// ----------------------------------------
	task automatic sc(logic ir, logic [31:0] d, int n, logic [31:0] m, logic [31:0] e);
		notes.push_back({m, e});
		@(posedge core_clk_in);
		#1 host.scan(ir, d, n);
	endtask
	task automatic op(logic [7:0] code);
		sc(1'b1, 32'(code), 8, 32'h0000_00FF, 32'h0000_0001);
	endtask
	task automatic pg(logic [13:0] w);
		op(OP_PROGRAM);
		sc(1'b0, 32'(w), 14, '0, '0);
	endtask
	task automatic vf(logic [3:0] a, logic [13:0] e);
		op(OP_VERIFY);
		sc(1'b0, 32'({2'b00, a, 8'h00}), 14, '0, '0);
		sc(1'b0, 32'({2'b00, a, 8'h00}), 14, 32'h0000_3FFF, 32'(e));
	endtask
	// Counts the cycles that user registers spend initialising
	task automatic wait_gsr();
		int k;
		k = 0;
		while (global_set_reset !== 1'b1 && k < 400) begin
			@(posedge core_clk_in);
			#1;
			k++;
		end
		if (k >= 400) begin
			errors++;
			close_out();
		end
		k = 0;
		while (global_set_reset === 1'b1 && k < 400) begin
			@(posedge core_clk_in);
			#1;
			k++;
		end
		chk(32'(k), 32'(INIT_N));
		repeat (2) @(posedge core_clk_in);
		#1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] ops [7] = '{OP_EXTEST, OP_SAMPLE, OP_INTEST, OP_IDCODE,
			OP_USERCODE, OP_HIGHZ, OP_BYPASS};
		logic [7:0] d;
		logic [31:0] r;
		void'($urandom(21835));
		repeat (16) @(posedge core_clk_in);
		#1 rst_b_in = 1'b1;
		repeat (4) @(posedge core_clk_in);
		chk(32'(mode), 32'h0000_0006);
		chk(32'(pin_out), 32'(PRE));
		#1 vcc_good_in = 1'b1;
		wait_gsr();
		chk(32'(mode), 32'h0000_0006);
		host.rst_tap();
		sc(1'b0, '0, 32, '1, ID);
		op(OP_ENTER);
		repeat (3) @(posedge core_clk_in);
		chk(32'({isp, pu, oe_b}), 32'h0000_0007);
		d = 8'($urandom());
		pg({6'h03, d});
		vf(4'h3, {6'h03, d});
		pg(14'h2500);
		vf(4'h3, 14'h2300);
		pg(14'h3600);
		op(OP_ERASE);
		pg(14'h1300);
		vf(4'h3, 14'h3300);
		pg(14'h0300);
		vf(4'h3, 14'h2300);
		op(OP_ERASE);
		vf(4'h3, 14'h0300);
		pg({6'h03, d});
		fork
			op(OP_EXIT);
			wait_gsr();
		join
		chk(32'(mode), 32'h0000_0001);
		@(posedge core_clk_in);
		#1 pin_in = 8'($urandom());
		core_in = 8'($urandom());
		repeat (6) @(posedge core_clk_in);
		chk(32'(pin_out), 32'(core_in));
		chk(32'(uin), 32'(pin_in));
		#1 host.rst_tap();
		foreach (ops[i]) begin
			op(ops[i]);
			r = $urandom();
			case (ops[i])
				OP_IDCODE: sc(1'b0, r, 32, '1, ID);
				OP_USERCODE: sc(1'b0, r, 32, '1, UC);
				OP_BYPASS: sc(1'b0, r, 32, '1, {r[30:0], 1'b0});
				OP_HIGHZ: begin
					sc(1'b0, r, 1, '0, '0);
					chk(32'(oe_b), 32'h0000_0001);
				end
				OP_EXTEST: begin
					sc(1'b0, r, IO_W, '0, '0);
					chk(32'(pin_out), 32'(r[IO_W-1:0]));
				end
				OP_SAMPLE: sc(1'b0, r, IO_W, 32'h0000_00FF, 32'(pin_in));
				OP_INTEST: begin
					sc(1'b0, r, IO_W, '0, '0);
					chk(32'(uin), 32'(r[IO_W-1:0]));
				end
				default: sc(1'b0, r, IO_W, '0, '0);
			endcase
		end
		@(posedge core_clk_in);
		#1 vcc_good_in = 1'b0;
		repeat (5) @(posedge core_clk_in);
		chk(32'(mode), 32'h0000_0006);
		#1 vcc_good_in = 1'b1;
		wait_gsr();
		chk(32'(mode), 32'h0000_0001);
		close_out();
	end
endmodule

// *** testbench/jtag_host.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// Boundary-scan programming host
// ----------------------------------------
module jtag_host (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in,
	input wire logic tdo_oe_b_in
);
	event got;
	logic [31:0] last;
	// Released data line reads high through its pull-up
	wire logic tdo_line = tdo_oe_b_in ? 1'b1 : tdo_in;
	// Test clock stands low between frames
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end
	// One 80 ns test clock, answer taken at the rise
	task automatic tk(input logic m, input logic d, output logic o);
		tms_out = m;
		tdi_out = d;
		#40 tck_out = 1'b1;
		o = tdo_line;
		#40 tck_out = 1'b0;
	endtask
	// Five ones reach test-logic-reset, then idle
	task automatic rst_tap();
		logic o;
		repeat (5) tk(1'b1, 1'b0, o);
		tk(1'b0, 1'b0, o);
	endtask
	// Scan n bits LSB first through IR or DR, back to idle
	task automatic scan(input logic ir, input logic [31:0] d, input int n);
		logic o;
		last = '0;
		tk(1'b1, 1'b0, o);
		if (ir) tk(1'b1, 1'b0, o);
		tk(1'b0, 1'b0, o);
		tk(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tk(i == n - 1, d[i], o);
			last[i] = o;
		end
		tk(1'b1, 1'b0, o);
		tk(1'b0, 1'b0, o);
		tk(1'b0, 1'b0, o);
		-> got;
	endtask
endmodule
